// File: rtl/output_mix_volume_regs.sv
// Left headphone mixer volume register bank on AHB-Lite
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module output_mix_volume_regs import mixvol_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Mixer path controls, one lane per source
  output logic [NUM_SRC-1:0] route_en,
  output logic [NUM_SRC*CODE_W-1:0] atten_code,
  output logic [NUM_SRC-1:0] path_mute,
  output logic [NUM_SRC-1:0] path_live
);

  // ========================================
  // Declarations
  bank_s r;
  bank_s nxt;
  logic rd_take;
  slot_t rd_slot;
  logic wr_pend;
  slot_t wr_slot;

  // ========================================
  // Bus front end
  ahb_slot_capture u_capture (
    .clock(clock),
    .reset_n(reset_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .rd_take(rd_take),
    .rd_slot(rd_slot),
    .wr_pend(wr_pend),
    .wr_slot(wr_slot)
  );

  // Zero wait states, so the bank never stretches a transfer
  // Limitation: no back-pressure is ever offered; the bank is small enough
  // that every access completes in a single data phase
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = r.rdata;

  // ========================================
  // Register update and read path
  // Read data is taken from the next value so a read right after a write
  // sees the new setting without an extra wait state
  always_comb begin
    nxt = r;
    if (wr_pend) begin
      nxt.vol[wr_slot] = hwdata[7:0];
    end
    if (rd_take) begin
      nxt.rd_q = 1'b1;
      nxt.rd_slot_q = rd_slot;
      if (rd_slot != NO_SLOT) begin
        nxt.rdata = {24'h0, nxt.vol[rd_slot]};
      end else begin
        nxt.rdata = 32'h0;
      end
    end else if (hready) begin
      nxt.rd_q = 1'b0;
      nxt.rd_slot_q = NO_SLOT;
    end
  end

  // Synchronous reset keeps the whole bank on one clock with no async paths
  // State register; every path setting starts unrouted at 0 dB
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      r <= '{vol: {NUM_SRC{VOL_RESET}}, rdata: 32'h0, rd_q: 1'b0, rd_slot_q: NO_SLOT};
    end else begin
      r <= nxt;
    end
  end

  // ========================================
  // Per-source path decode
  // Each source owns its own register and decoder, so no path
  // setting ever leaks into another
  for (genvar k = 0; k < NUM_SRC; k++) begin : g_path
    mix_path_decode u_decode (
      .setting(r.vol[k]),
      .route_en(route_en[k]),
      .atten_code(atten_code[k*CODE_W +: CODE_W]),
      .path_mute(path_mute[k]),
      .path_live(path_live[k])
    );

    // Mute band and live flag follow the stored code
    mute_band_a: assert property (@(posedge clock) disable iff (!reset_n)
      path_mute[k] == (r.vol[k][CODE_W-1:0] > DEEPEST_CODE)
      && path_live[k] == (r.vol[k][ROUTE_BIT] && !path_mute[k]))
      else $error("mute band or live flag wrong");

    // Route and code outputs are the stored bits and nothing else
    decode_map_a: assert property (@(posedge clock) disable iff (!reset_n)
      route_en[k] == r.vol[k][ROUTE_BIT] && atten_code[k*CODE_W +: CODE_W] == r.vol[k][CODE_W-1:0])
      else $error("path outputs differ from stored setting");

    // Finite codes up to the deepest step pass the signal
    finite_pass_a: assert property (@(posedge clock) disable iff (!reset_n)
      r.vol[k][CODE_W-1:0] <= DEEPEST_CODE |-> !path_mute[k])
      else $error("finite code muted the path");

    // A muted code keeps its route bit visible but silences the lane
    mute_route_a: assert property (@(posedge clock) disable iff (!reset_n)
      path_mute[k] |-> !path_live[k] && route_en[k] == r.vol[k][ROUTE_BIT])
      else $error("muted lane still live");

    // A setting only moves when its own lane is written
    lane_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
      !(wr_pend && wr_slot == k) |=> $stable(r.vol[k]))
      else $error("lane setting moved without a write");

    // Each lane takes exactly the written byte
    lane_write_a: assert property (@(posedge clock) disable iff (!reset_n)
      wr_pend && wr_slot == k |=> r.vol[k] == $past(hwdata[7:0]))
      else $error("lane did not take the written byte");
  end

  // ========================================
  // Checks
  // Bus timing seen by these checks: an address phase is taken at edge n,
  // a write lands at edge n+1 and shows on the lane outputs after it, and
  // read data is loaded at edge n and stands through the data phase.
  // The slave never inserts wait states, so hready is high in practice;
  // the checks still qualify on it so that a later wait-state version
  // does not make them fire falsely.
  // Reset is synchronous, so every check is simply switched off while
  // reset_n is low and picks up again at the first edge after release.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // Data phase of a write to one slot
  sequence s_wr(int k);
    wr_pend && wr_slot == k;
  endsequence

  // Address phase of a read to one slot
  sequence s_rd(int k);
    rd_take && rd_slot == k;
  endsequence

  // A written route bit shows on the path output one cycle later
  property p_route(int k);
    s_wr(k) |=> route_en[k] == $past(hwdata[ROUTE_BIT]);
  endproperty

  // Write then read of the same slot returns the written byte
  property p_readback(int k);
    s_wr(k) ##0 s_rd(k) |=> hrdata == {24'h0, $past(hwdata[7:0])};
  endproperty

  // Read address phase aimed at one printed register index
  sequence s_rd_at(logic [7:0] idx);
    hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && hsize == HSIZE_WORD
      && haddr == {22'h0, idx, 2'b00};
  endsequence

  // Write address phase aimed at one printed register index
  sequence s_wr_at(logic [7:0] idx);
    hsel && hready && htrans == HTRANS_NONSEQ && hwrite && hsize == HSIZE_WORD
      && haddr == {22'h0, idx, 2'b00};
  endsequence

  // Word write address phase that hits none of the five registers
  sequence s_wr_off;
    hsel && hready && htrans == HTRANS_NONSEQ && hwrite && hsize == HSIZE_WORD
      && haddr != {22'h0, LINE2_LEFT_IDX, 2'b00} && haddr != {22'h0, PREAMP_LEFT_IDX, 2'b00}
      && haddr != {22'h0, DAC_LEFT_IDX, 2'b00} && haddr != {22'h0, LINE2_RIGHT_IDX, 2'b00}
      && haddr != {22'h0, PREAMP_RIGHT_IDX, 2'b00};
  endsequence

  // No write data phase lands in the same cycle
  sequence s_no_wr;
    !wr_pend;
  endsequence

  // A plain read of one register returns its stored byte next cycle
  property p_map(logic [7:0] idx, int k);
    s_rd_at(idx) ##0 s_no_wr |=> hrdata == {24'h0, $past(r.vol[k])};
  endproperty

  // A write to one index shows on that lane once its data phase is over;
  // the extra cycle is the data phase in which hwdata stands
  property p_wmap(logic [7:0] idx, int k);
    s_wr_at(idx) |=> ##1 route_en[k] == $past(hwdata[ROUTE_BIT])
      && atten_code[k*CODE_W +: CODE_W] == $past(hwdata[CODE_W-1:0]);
  endproperty

  left_line_route_a: assert property (p_route(0))
    else $error("left line two route bit not applied");
  preamp_l_route_a: assert property (p_route(1))
    else $error("left preamp route bit not applied");
  dac_l_route_a: assert property (p_route(2))
    else $error("left converter route bit not applied");
  right_line_route_a: assert property (p_route(3))
    else $error("right line two route bit not applied");
  preamp_r_route_a: assert property (p_route(4))
    else $error("right preamp route bit not applied");

  // Out of reset every path is off and at 0 dB
  code_reset_a: assert property ($rose(reset_n) |-> route_en == '0 && atten_code == '0)
    else $error("path settings not cleared by reset");

  // A written code reaches the attenuation output in one cycle
  code_write_a: assert property (wr_pend |=>
    atten_code[$past(wr_slot)*CODE_W +: CODE_W] == $past(hwdata[CODE_W-1:0]))
    else $error("attenuation code not applied");

  // A write leaves every other slot untouched
  others_stable_a: assert property (wr_pend |=>
    (r.vol & ~({{(NUM_SRC-1)*8{1'b0}}, 8'hFF} << ($past(wr_slot) * 8)))
    == ($past(r.vol) & ~({{(NUM_SRC-1)*8{1'b0}}, 8'hFF} << ($past(wr_slot) * 8))))
    else $error("write disturbed another slot");

  // Read data phase shows the stored byte, upper bits zero
  read_data_a: assert property (r.rd_q && r.rd_slot_q != NO_SLOT |->
    hrdata == {24'h0, r.vol[r.rd_slot_q]})
    else $error("read data does not match register");

  read_after_write_a: assert property (p_readback(2))
    else $error("read after write lost the new value");

  // Unmapped addresses read as zero
  unmapped_zero_a: assert property (r.rd_q && r.rd_slot_q == NO_SLOT |-> hrdata == 32'h0)
    else $error("unmapped read not zero");

  // Bus answer is always ready and OKAY
  bus_okay_a: assert property (hreadyout && hresp == HRESP_OKAY)
    else $error("bus answer not ready or not OKAY");

  // ========================================
  // Address map checks, one per printed index
  map_line_left_a: assert property (p_map(LINE2_LEFT_IDX, 0))
    else $error("left line two register read from the wrong lane");
  map_preamp_left_a: assert property (p_map(PREAMP_LEFT_IDX, 1))
    else $error("left preamp register read from the wrong lane");
  map_dac_left_a: assert property (p_map(DAC_LEFT_IDX, 2))
    else $error("left converter register read from the wrong lane");
  map_line_right_a: assert property (p_map(LINE2_RIGHT_IDX, 3))
    else $error("right line two register read from the wrong lane");
  map_preamp_right_a: assert property (p_map(PREAMP_RIGHT_IDX, 4))
    else $error("right preamp register read from the wrong lane");

  // Writes by address land on the matching lane outputs
  wmap_line_left_a: assert property (p_wmap(LINE2_LEFT_IDX, 0))
    else $error("left line two write landed on the wrong lane");
  wmap_preamp_left_a: assert property (p_wmap(PREAMP_LEFT_IDX, 1))
    else $error("left preamp write landed on the wrong lane");
  wmap_dac_left_a: assert property (p_wmap(DAC_LEFT_IDX, 2))
    else $error("left converter write landed on the wrong lane");
  wmap_line_right_a: assert property (p_wmap(LINE2_RIGHT_IDX, 3))
    else $error("right line two write landed on the wrong lane");
  wmap_preamp_right_a: assert property (p_wmap(PREAMP_RIGHT_IDX, 4))
    else $error("right preamp write landed on the wrong lane");

  // Back to back write and read works on lanes 0, 1, 3 and 4
  rbw_line_left_a: assert property (p_readback(0))
    else $error("read after write lost the new value");
  rbw_preamp_left_a: assert property (p_readback(1))
    else $error("read after write lost the new value");
  rbw_line_right_a: assert property (p_readback(3))
    else $error("read after write lost the new value");
  rbw_preamp_right_a: assert property (p_readback(4))
    else $error("read after write lost the new value");

  // ========================================
  // Bus front end checks
  // A write data phase only follows an accepted write address phase of at most a word
  wr_origin_a: assert property (wr_pend |->
    $past(hsel && hready && htrans[1] && hwrite && hsize <= HSIZE_WORD))
    else $error("write data phase without a write address phase");

  // A pending write always names a real lane
  wr_slot_valid_a: assert property (wr_pend |-> wr_slot < NUM_SRC)
    else $error("pending write names no lane");

  // Oversized transfers are dropped rather than byte-laned
  size_refused_a: assert property (hsel && htrans[1] && hwrite && hsize > HSIZE_WORD |=> !wr_pend)
    else $error("oversized write accepted");

  // An oversized read leaves the previous read data in place
  size_read_hold_a: assert property (hsel && htrans[1] && !hwrite && hsize > HSIZE_WORD |=>
    $stable(hrdata))
    else $error("oversized read changed the read data");

  // Without select nothing is written
  unselected_a: assert property (!hsel |=> !wr_pend)
    else $error("write accepted without select");

  // A write outside the map stores nothing
  unmapped_store_a: assert property (s_wr_off |=> ##1 $stable(r.vol))
    else $error("unmapped write changed a lane");

  // Read data holds until the next accepted read
  rdata_hold_a: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data moved without a read");

  // Every accepted read opens a read data phase
  rd_flag_a: assert property (rd_take |=> r.rd_q)
    else $error("read data phase not marked");

  // The read data phase ends with the next cycle that takes no read
  rd_flag_clear_a: assert property (!rd_take && hready |=> !r.rd_q)
    else $error("read data phase did not end");

  // Lane outputs move only when a write lands; mixing never glitches
  // between writes
  outputs_hold_a: assert property (!wr_pend |=> $stable(route_en) && $stable(atten_code))
    else $error("lane outputs moved without a write");

  // Upper read data bits are always zero
  rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");

  // Live flags across all lanes: routed and not muted
  live_all_a: assert property (path_live == (route_en & ~path_mute))
    else $error("live flags disagree with route and mute");

  // Out of reset no lane is muted or live and the read data is clear
  reset_flags_a: assert property ($rose(reset_n) |->
    path_mute == '0 && path_live == '0 && hrdata == 32'h0)
    else $error("flags or read data not cleared by reset");

  // Out of reset the stored bytes are all zero
  reset_regs_a: assert property ($rose(reset_n) |-> r.vol == '0 && r.rdata == 32'h0)
    else $error("bank not cleared by reset");

endmodule : output_mix_volume_regs

// File: rtl/mixvol_pkg.sv
// Constants, types and address decoding for the headphone mixer volume bank
// What this block does
// - Left line two route bit seven
// - Left preamp route bit seven
// - Left converter path route bit seven
// - Right line two route bit seven
// - Right preamp route bit seven
// - Bits six to zero: attenuation, reset zero
// - Code zero is 0 dB, half-dB steps
// - Codes 118 to 127 mute the path
// - Every source path has independent control
package mixvol_pkg;

  // ========================================
  // Register map (printed index, byte address is index times four)
  localparam int NUM_SRC = 5;
  localparam logic [7:0] LINE2_LEFT_IDX = 8'h2D;
  localparam logic [7:0] PREAMP_LEFT_IDX = 8'h2E;
  localparam logic [7:0] DAC_LEFT_IDX = 8'h2F;
  localparam logic [7:0] LINE2_RIGHT_IDX = 8'h30;
  localparam logic [7:0] PREAMP_RIGHT_IDX = 8'h31;

  // ========================================
  // Field layout and reset values
  localparam int ROUTE_BIT = 7;
  localparam int CODE_W = 7;
  localparam logic [7:0] VOL_RESET = 8'h00;
  localparam logic [6:0] DEEPEST_CODE = 7'h75;
  localparam logic [6:0] MUTE_FIRST = 7'h76;

  // ========================================
  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef logic [2:0] slot_t;
  localparam slot_t NO_SLOT = 3'h7;

  // Address phase bookkeeping of the bus front end
  typedef struct packed {
    logic wr_pend;
    slot_t wr_slot;
  } capture_s;

  // Whole register bank state
  typedef struct packed {
    logic [NUM_SRC-1:0][7:0] vol;
    logic [31:0] rdata;
    logic rd_q;
    slot_t rd_slot_q;
  } bank_s;

  // Byte address to bank slot; anything else is unmapped
  function automatic slot_t slot_of(input logic [31:0] a);
    slot_t s;
    s = NO_SLOT;
    if (a == {22'h0, LINE2_LEFT_IDX, 2'b00}) begin
      s = 3'h0;
    end else if (a == {22'h0, PREAMP_LEFT_IDX, 2'b00}) begin
      s = 3'h1;
    end else if (a == {22'h0, DAC_LEFT_IDX, 2'b00}) begin
      s = 3'h2;
    end else if (a == {22'h0, LINE2_RIGHT_IDX, 2'b00}) begin
      s = 3'h3;
    end else if (a == {22'h0, PREAMP_RIGHT_IDX, 2'b00}) begin
      s = 3'h4;
    end
    return s;
  endfunction : slot_of

endpackage : mixvol_pkg

// File: rtl/ahb_slot_capture.sv
// AHB-Lite address phase capture and slot decode for the volume bank
`timescale 1ns/1ps
module ahb_slot_capture import mixvol_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Address phase
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  // Decoded requests
  output logic rd_take,
  output slot_t rd_slot,
  output logic wr_pend,
  output slot_t wr_slot
);

  capture_s r;
  capture_s nxt;
  logic take;
  slot_t slot;

  // Only NONSEQ or SEQ of at most a word is a real transfer
  assign take = hsel && hready && htrans[1] && (hsize <= HSIZE_WORD);
  assign slot = slot_of(haddr);
  assign rd_take = take && !hwrite;
  assign rd_slot = slot;
  assign wr_pend = r.wr_pend;
  assign wr_slot = r.wr_slot;

  // Writes land one cycle later, when hwdata is on the bus
  always_comb begin
    nxt = r;
    if (hready) begin
      nxt.wr_pend = take && hwrite && (slot != NO_SLOT);
      nxt.wr_slot = slot;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      r <= '{wr_pend: 1'b0, wr_slot: NO_SLOT};
    end else begin
      r <= nxt;
    end
  end

endmodule : ahb_slot_capture

// File: rtl/mix_path_decode.sv
// Decode of one mixer path setting into mute and live flags
`timescale 1ns/1ps
module mix_path_decode import mixvol_pkg::*; (
  // Register contents
  input wire logic [7:0] setting,
  // Path control
  output logic route_en,
  output logic [CODE_W-1:0] atten_code,
  output logic path_mute,
  output logic path_live
);

  // Route switch and half-dB attenuation code pass straight through
  assign route_en = setting[ROUTE_BIT];
  assign atten_code = setting[CODE_W-1:0];

  // Top codes past the deepest finite step silence the path
  assign path_mute = (setting[CODE_W-1:0] >= MUTE_FIRST);
  assign path_live = route_en && !path_mute;

endmodule : mix_path_decode

// File: tb/test_output_mix_volume_regs.sv
// Self-checking bench for the headphone mixer volume register bank
`timescale 1ns/1ps
module test_output_mix_volume_regs import mixvol_pkg::*;;
  // ========================================
  // Stimulus and observation
  logic clock, reset_n, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp;
  logic [NUM_SRC-1:0] route_en, path_mute, path_live;
  logic [NUM_SRC*CODE_W-1:0] atten_code;
  logic [7:0] model [NUM_SRC];
  int num_errors = 0;
  int check_count = 0;

  // Single slave, so its ready is the bus ready
  output_mix_volume_regs output_mix_volume_regs_i (.clock(clock), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .route_en(route_en), .atten_code(atten_code), .path_mute(path_mute), .path_live(path_live));

  // ========================================
  // Helpers
  task automatic check(input string nm, input int k, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s lane %0d expected %h seen %h", nm, k, exp, got);
    end
  endtask : check

  function automatic logic [31:0] reg_addr(input int k);
    logic [7:0] idx [NUM_SRC];
    idx = '{LINE2_LEFT_IDX, PREAMP_LEFT_IDX, DAC_LEFT_IDX, LINE2_RIGHT_IDX, PREAMP_RIGHT_IDX};
    return {22'h0, idx[k], 2'b00};
  endfunction : reg_addr

  // Wait for ready under a bound; entered and left right after a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
  endtask : wait_ready

  // One single transfer; read data taken at the data phase edge
  task automatic xfer_raw(input logic sel, input logic [2:0] size, input logic wr, input logic [31:0] addr,
                          input logic [31:0] wd, output logic [31:0] rd);
    hsel <= sel;
    haddr <= addr;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= size;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check("hresp", 0, {31'h0, HRESP_OKAY}, {31'h0, hresp});
  endtask : xfer_raw

  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
    xfer_raw(1'b1, HSIZE_WORD, wr, addr, wd, rd);
  endtask : xfer

  task automatic write_lane(input int k, input logic [31:0] wd);
    logic [31:0] rd;
    xfer(1'b1, reg_addr(k), wd, rd);
    model[k] = wd[7:0];
  endtask : write_lane

  // Outputs land at the data phase edge and are checked just after it, then read back all
  task automatic check_all();
    logic [31:0] rd;
    #1;
    for (int k = 0; k < NUM_SRC; k++) begin
      check("route_en", k, {31'h0, model[k][ROUTE_BIT]}, {31'h0, route_en[k]});
      check("atten_code", k, {25'h0, model[k][6:0]}, {25'h0, atten_code[k*CODE_W +: CODE_W]});
      check("path_mute", k, {31'h0, model[k][6:0] >= MUTE_FIRST}, {31'h0, path_mute[k]});
      check("path_live", k, {31'h0, model[k][7] && model[k][6:0] < MUTE_FIRST}, {31'h0, path_live[k]});
    end
    @(posedge clock);
    for (int k = 0; k < NUM_SRC; k++) begin
      xfer(1'b0, reg_addr(k), 32'h0, rd);
      check("readback", k, {24'h0, model[k]}, rd);
    end
  endtask : check_all

  // ========================================
  // Scenarios
  task automatic reset_values();
    for (int k = 0; k < NUM_SRC; k++) model[k] = VOL_RESET;
    check_all();
  endtask : reset_values

  // Mute boundary codes on different lanes, upper data bits ignored
  task automatic lanes_independent();
    logic [31:0] vals [NUM_SRC];
    vals = '{32'hFFFFFF80, 32'h000000F5, 32'h000000F6, 32'h0000007F, 32'h00000001};
    for (int k = 0; k < NUM_SRC; k++) write_lane(k, vals[k]);
    check_all();
    write_lane(2, 32'h00000075);
    write_lane(0, 32'h00000000);
    check_all();
  endtask : lanes_independent

  // Unmapped places neither store nor answer with data
  task automatic unmapped_access();
    logic [31:0] rd;
    xfer(1'b1, 32'h000000B0, 32'h000000FF, rd);
    xfer(1'b1, 32'h000000C8, 32'h000000FF, rd);
    xfer(1'b0, 32'h000000B0, 32'h0, rd);
    check("unmapped_read", 0, 32'h0, rd);
    check_all();
  endtask : unmapped_access

  // Read address phase placed in the write data phase of the same lane
  task automatic write_then_read();
    logic [31:0] rd;
    logic [7:0] vals [NUM_SRC];
    vals = '{8'h40, 8'hD1, 8'h76, 8'h75, 8'hFF};
    for (int k = 0; k < NUM_SRC; k++) begin
      hsel <= 1'b1;
      haddr <= reg_addr(k);
      htrans <= HTRANS_NONSEQ;
      hwrite <= 1'b1;
      hsize <= HSIZE_WORD;
      wait_ready();
      hwrite <= 1'b0;
      hwdata <= {24'h0, vals[k]};
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      wait_ready();
      rd = hrdata;
      model[k] = vals[k];
      check("read_after_write", k, {24'h0, model[k]}, rd);
    end
    check_all();
  endtask : write_then_read

  // Oversized and unselected transfers leave every lane alone
  task automatic refused_access();
    logic [31:0] rd;
    xfer(1'b0, reg_addr(1), 32'h0, rd);
    xfer_raw(1'b1, 3'h3, 1'b1, reg_addr(1), 32'h000000AA, rd);
    xfer_raw(1'b0, HSIZE_WORD, 1'b1, reg_addr(3), 32'h000000AA, rd);
    xfer_raw(1'b1, 3'h3, 1'b0, reg_addr(0), 32'h0, rd);
    check("oversized_read", 1, {24'h0, model[1]}, rd);
    check_all();
  endtask : refused_access

  // Reset in mid run clears every lane again
  task automatic mid_reset();
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    for (int k = 0; k < NUM_SRC; k++) model[k] = VOL_RESET;
    check_all();
  endtask : mid_reset

  // ========================================
  // Clock, watchdog and main sequence
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic conclude();
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // Whole run is about 140 cycles
  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    conclude();
  end

  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    reset_values();
    lanes_independent();
    unmapped_access();
    write_then_read();
    refused_access();
    mid_reset();
    conclude();
  end
endmodule : test_output_mix_volume_regs
